// >>> hdl/flash_status_protect_hold.sv
// status register, write protection and hold logic of a serial nor flash
// Behaviour
// - while paused: output floats, clock and input edges ignored
// - pause starts on hold falling, clock low, chip selected
// - pause ends on hold rising while clock is low
// - deselect during pause resets interface, drops the transfer
// - busy bit is 1 during program, erase or status write
// - write enable latch bit; when 0 writes, programs, erases rejected
// - write enable sets latch; disable, writes, erases, resets clear it
// - block-protect field written by status write, guards the array
// - block-protect writable only outside hardware-protected mode
// - chip erase only with low protect bits matching complement bit
// - quad enable defaults 0; when 1 pause and protect pins are data
// - quad command mode needs quad enable; then enable cannot clear
// - security lock bits one-time settable, cleared only by power cycle
// - complement bit inverts the protected region
// - suspend flags set by suspend, cleared by resume or power-up
// - high performance flag reads 1 while that mode is active
// - two-bit drive strength field, default three quarters
// - protect mode 00: writable whenever latch set
// - protect mode 01: low protect pin locks status writes
// - protect mode 10: locked until power cycle, which returns 00
// - protect mode 11: status register not writable until power cycle, which returns 00
// - in deep power-down only the release instruction and status reads are taken
module flash_status_protect_hold #(
    parameter int BUSY_CYCLES = 64
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic hold_n,
    input wire logic wp_n,
    output logic miso,
    output logic miso_oe,
    output flash_pkg::status_t status,
    output logic quad_io_enable,
    output logic quad_command_mode,
    output logic deep_power_down
);
    import flash_pkg::*;

    localparam logic [BUSY_W-1:0] BUSY_LOAD = BUSY_W'(BUSY_CYCLES);

    frame_t frm_r;
    logic [7:0] sh_r;
    logic [7:0] sh_nxt;
    logic [11:0] cnt_nxt;
    logic fresh_r;
    logic frame_idle;
    logic take;
    logic qe_l;
    logic miso_r;
    logic oe_l_r;
    logic [7:0] out_byte;
    logic [23:0] snap_r;

    logic cs_s, sclk_s, hold_s, wp_s, oe_s;
    logic cs_d_r, hold_d_r;
    logic cs_rise, cs_fall;
    logic paused_r;
    logic exec_r;
    logic miso_oe_r;

    status_t st_r;
    status_t new_s;
    logic [23:0] new_w;
    busy_t busy_r, held_r, start;
    logic [BUSY_W-1:0] busy_cnt_r;
    logic busy, busy_end, go8, on_byte, sr_open, ce_ok, prot_hit;
    logic set_wel, clr_wel, wr_sr, do_susp, do_resm, soft_rst;
    logic dpd_r, qpi_r, rsten_r;

    // link side: frame state lives on the host's serial clock
    assign frame_idle = cs_n | ~nrst;
    // edges taken only when not held
    assign take = ~cs_n & (hold_n | qe_l);
    assign cnt_nxt = fresh_r ? CNT_ONE : frm_r.cnt + CNT_ONE;
    assign sh_nxt = {sh_r[6:0], mosi};
    assign out_byte = rd_byte(frm_r.op, snap_r);

    pin_sync #(.W(1), .RST(1'b0)) u_qe_sync (
        .clk(sclk),
        .nrst(nrst),
        .d(st_r.qe),
        .q(qe_l)
    );

    // deselect clears the position in the frame
    always_ff @(posedge sclk or posedge frame_idle)
    begin
        if (frame_idle)
            fresh_r <= 1'b1;
        else if (take)
            fresh_r <= 1'b0;
    end

    // count survives deselect so the clock side can judge the frame
    always_ff @(posedge sclk or negedge nrst)
    begin
        if (!nrst)
        begin
            frm_r <= '0;
            sh_r <= '0;
        end
        else if (take)
        begin
            sh_r <= sh_nxt;
            frm_r.cnt <= cnt_nxt;
            if (cnt_nxt == CNT_OP)
                frm_r.op <= sh_nxt;
            if (cnt_nxt == CNT_B2)
                frm_r.b2 <= sh_nxt;
            if (cnt_nxt == CNT_B3)
                frm_r.b3 <= sh_nxt;
        end
    end

    // snapshot is static from select until long after the opcode
    always_ff @(negedge sclk or posedge frame_idle)
    begin
        if (frame_idle)
        begin
            miso_r <= 1'b0;
            oe_l_r <= 1'b0;
        end
        else if (take)
        begin
            oe_l_r <= frm_r.cnt >= CNT_OP && is_read(frm_r.op);
            miso_r <= out_byte[BIT_TOP - frm_r.cnt[2:0]];
        end
    end

    // clock side
    pin_sync #(.W(5), .RST(PIN_SYNC_RST)) u_pin_sync (
        .clk(clk),
        .nrst(nrst),
        .d({cs_n, sclk, hold_n, wp_n, oe_l_r}),
        .q({cs_s, sclk_s, hold_s, wp_s, oe_s})
    );

    assign cs_rise = cs_s & ~cs_d_r;
    assign cs_fall = ~cs_s & cs_d_r;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cs_d_r <= 1'b1;
            hold_d_r <= 1'b1;
            exec_r <= 1'b0;
            miso_oe_r <= 1'b0;
            snap_r <= '0;
        end
        else
        begin
            cs_d_r <= cs_s;
            hold_d_r <= hold_s;
            // frame ended inside a pause is abandoned
            exec_r <= cs_rise & ~paused_r;
            miso_oe_r <= oe_s & ~cs_s & ~paused_r;
            if (cs_fall)
                snap_r <= st_r;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            paused_r <= 1'b0;
        else if (cs_s)
            paused_r <= 1'b0;
        else if (!st_r.qe && hold_d_r && !hold_s && !sclk_s)
            paused_r <= 1'b1;
        else if (hold_s && !hold_d_r && !sclk_s)
            paused_r <= 1'b0;
    end

    // command decode, run once per finished frame
    assign busy = busy_r != BUSY_IDLE;
    assign busy_end = busy && busy_cnt_r == BUSY_ONE;
    assign on_byte = frm_r.cnt[2:0] == BIT_ZERO;
    assign go8 = exec_r && !dpd_r && !busy && frm_r.cnt == CNT_OP;
    assign soft_rst = go8 && frm_r.op == OP_RST && rsten_r;
    assign ce_ok = (st_r.bp[2:0] == BP_CE_NONE && !st_r.cmp) ||
                   (st_r.bp[2:0] == BP_CE_ALL && st_r.cmp);
    assign prot_hit = addr_protected(frm_r.b2[4:0], frm_r.b3[7:4],
                                     st_r.bp, st_r.cmp);
    assign new_s = status_t'(new_w);

    always_comb
    begin
        case (st_r.srp)
            SRP_SOFT: sr_open = st_r.write_enable_latch;
            // with quad enable the pin is data, not a lock
            SRP_HW: sr_open = st_r.write_enable_latch && (wp_s || st_r.qe);
            default: sr_open = 1'b0;
        endcase
    end

    always_comb
    begin
        start = BUSY_IDLE;
        set_wel = 1'b0;
        clr_wel = 1'b0;
        wr_sr = 1'b0;
        do_susp = 1'b0;
        do_resm = 1'b0;
        new_w = st_r;
        if (!exec_r || dpd_r)
            start = BUSY_IDLE;
        else if (busy)
            do_susp = frm_r.op == OP_SUSP && frm_r.cnt == CNT_OP &&
                      busy_r != BUSY_WRSR;
        else
            case (frm_r.op)
                OP_WREN: set_wel = frm_r.cnt == CNT_OP;
                OP_WRDI: clr_wel = frm_r.cnt == CNT_OP;
                OP_WRSR, OP_WRSR2, OP_WRSR3:
                begin
                    if (frm_r.op == OP_WRSR3)
                        new_w[2 * BYTE_W +: BYTE_W] = frm_r.b2;
                    else if (frm_r.op == OP_WRSR2)
                        new_w[BYTE_W +: BYTE_W] = frm_r.b2;
                    else
                        new_w[0 +: BYTE_W] = frm_r.b2;
                    if (frm_r.op == OP_WRSR && frm_r.cnt == CNT_B3)
                        new_w[BYTE_W +: BYTE_W] = frm_r.b3;
                    if (st_r.write_enable_latch && (frm_r.cnt == CNT_B2 ||
                        (frm_r.op == OP_WRSR && frm_r.cnt == CNT_B3)))
                    begin
                        clr_wel = 1'b1;
                        wr_sr = sr_open;
                        start = sr_open ? BUSY_WRSR : BUSY_IDLE;
                    end
                end
                OP_PP, OP_QPP:
                    if (st_r.write_enable_latch && on_byte && frm_r.cnt >= CNT_PP)
                    begin
                        clr_wel = 1'b1;
                        if (!prot_hit && !st_r.erase_suspended_flag && !st_r.program_suspended_flag)
                            start = BUSY_PROG;
                    end
                OP_SE, OP_BE32, OP_BE64:
                    if (st_r.write_enable_latch && frm_r.cnt == CNT_ERASE)
                    begin
                        clr_wel = 1'b1;
                        if (!prot_hit && !st_r.erase_suspended_flag && !st_r.program_suspended_flag)
                            start = BUSY_ERASE;
                    end
                OP_CE1, OP_CE2:
                    if (st_r.write_enable_latch && frm_r.cnt == CNT_OP)
                    begin
                        clr_wel = 1'b1;
                        if (ce_ok && !st_r.erase_suspended_flag && !st_r.program_suspended_flag)
                            start = BUSY_ERASE;
                    end
                OP_RESM: do_resm = frm_r.cnt == CNT_OP;
                default: start = BUSY_IDLE;
            endcase
    end

    // array timing is not modelled: a fixed busy span stands in for it
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            busy_r <= BUSY_IDLE;
            held_r <= BUSY_IDLE;
            busy_cnt_r <= '0;
        end
        else if (start != BUSY_IDLE)
        begin
            busy_r <= start;
            busy_cnt_r <= BUSY_LOAD;
        end
        else if (do_susp)
        begin
            held_r <= busy_r;
            busy_r <= BUSY_IDLE;
        end
        else if (do_resm)
        begin
            busy_r <= held_r;
            held_r <= BUSY_IDLE;
        end
        else if (busy)
        begin
            if (busy_end)
                busy_r <= BUSY_IDLE;
            busy_cnt_r <= busy_cnt_r - BUSY_ONE;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r <= '0;
            st_r.drv <= DRV_RESET;
        end
        else
        begin
            st_r.write_in_progress <= start != BUSY_IDLE ||
                        (busy && !busy_end && !do_susp) ||
                        (do_resm && held_r != BUSY_IDLE);
            if (set_wel)
                st_r.write_enable_latch <= 1'b1;
            else if (clr_wel || soft_rst)
                st_r.write_enable_latch <= 1'b0;
            if (wr_sr)
            begin
                st_r.bp <= new_s.bp;
                st_r.srp <= new_s.srp;
                // quad mode pins quad enable high
                st_r.qe <= qpi_r | new_s.qe;
                st_r.lb <= st_r.lb | new_s.lb;
                st_r.cmp <= new_s.cmp;
                st_r.drv <= new_s.drv;
            end
            if (do_susp)
            begin
                st_r.erase_suspended_flag <= busy_r == BUSY_ERASE;
                st_r.program_suspended_flag <= busy_r == BUSY_PROG;
            end
            else if (do_resm)
            begin
                st_r.erase_suspended_flag <= 1'b0;
                st_r.program_suspended_flag <= 1'b0;
            end
            if (go8 && frm_r.op == OP_HPM)
                st_r.high_perf_flag <= 1'b1;
            else if (soft_rst)
                st_r.high_perf_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            dpd_r <= 1'b0;
            qpi_r <= 1'b0;
            rsten_r <= 1'b0;
        end
        else
        begin
            if (exec_r)
                rsten_r <= go8 && frm_r.op == OP_RSTEN;
            if (exec_r && dpd_r && frm_r.op == OP_RDPD &&
                frm_r.cnt == CNT_OP)
                dpd_r <= 1'b0;
            else if (go8 && frm_r.op == OP_DPD)
                dpd_r <= 1'b1;
            if (go8 && frm_r.op == OP_QPI_ON && st_r.qe)
                qpi_r <= 1'b1;
            else if (soft_rst || (go8 && frm_r.op == OP_QPI_OFF))
                qpi_r <= 1'b0;
        end
    end

    assign miso = miso_r;
    assign miso_oe = miso_oe_r;
    assign status = st_r;
    assign quad_io_enable = st_r.qe;
    assign quad_command_mode = qpi_r;
    assign deep_power_down = dpd_r;

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence wren_go_s;
        go8 && frm_r.op == OP_WREN;
    endsequence
    sequence wrdi_go_s;
        go8 && frm_r.op == OP_WRDI;
    endsequence
    sequence ce_bad_s;
        go8 && st_r.write_enable_latch && !ce_ok &&
        (frm_r.op == OP_CE1 || frm_r.op == OP_CE2);
    endsequence

    pause_float_a: assert property (paused_r |=> !miso_oe_r)
        else $error("output driven during pause");
    pause_start_a: assert property ($rose(paused_r) |->
        $past(!cs_s && !sclk_s && !hold_s))
        else $error("pause began without select and low clock");
    pause_end_a: assert property ($fell(paused_r) |->
        $past(cs_s || (hold_s && !sclk_s)))
        else $error("pause ended without cause");
    hold_abandon_a: assert property (cs_rise && paused_r |=>
        !exec_r && !paused_r)
        else $error("frame executed after deselect in pause");
    busy_flag_a: assert property (start != BUSY_IDLE |=>
        st_r.write_in_progress && busy)
        else $error("busy bit missing after accepted write");
    wel_gate_a: assert property (exec_r && !st_r.write_enable_latch |->
        start == BUSY_IDLE)
        else $error("write accepted with latch clear");
    wel_set_a: assert property (wren_go_s |=> st_r.write_enable_latch)
        else $error("write enable did not set latch");
    wel_clear_a: assert property (wrdi_go_s |=> !st_r.write_enable_latch)
        else $error("write disable did not clear latch");
    bp_hwlock_a: assert property (exec_r && st_r.srp == SRP_HW &&
        !wp_s && !st_r.qe |=> $stable(st_r.bp))
        else $error("protect field changed under pin lock");
    sr_frozen_a: assert property (st_r.srp[1] |=>
        $stable(st_r.srp) && $stable(st_r.bp))
        else $error("locked status register changed");
    chip_erase_a: assert property (ce_bad_s |=>
        !$rose(st_r.write_in_progress))
        else $error("chip erase ran with protection set");
    lock_sticky_a: assert property (st_r.lb != 3'h0 |=>
        (st_r.lb & $past(st_r.lb)) == $past(st_r.lb))
        else $error("security lock bit cleared");
    qpi_qe_a: assert property (qpi_r |-> st_r.qe)
        else $error("quad mode without quad enable");
    dpd_ignore_a: assert property (exec_r && dpd_r |=>
        $stable(st_r.write_enable_latch) && !$rose(st_r.write_in_progress))
        else $error("instruction acted in deep power-down");
    susp_flag_a: assert property (do_susp |=>
        (st_r.erase_suspended_flag ^ st_r.program_suspended_flag) && !busy)
        else $error("suspend did not flag and halt");
endmodule

// >>> hdl/flash_pkg.sv
// constants, types and helpers shared by the flash status logic
package flash_pkg;
    // instruction codes
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_WRSR2 = 8'h31;
    localparam logic [7:0] OP_WRSR3 = 8'h11;
    localparam logic [7:0] OP_RDSR1 = 8'h05;
    localparam logic [7:0] OP_RDSR2 = 8'h35;
    localparam logic [7:0] OP_RDSR3 = 8'h15;
    localparam logic [7:0] OP_PP = 8'h02;
    localparam logic [7:0] OP_QPP = 8'h32;
    localparam logic [7:0] OP_SE = 8'h20;
    localparam logic [7:0] OP_BE32 = 8'h52;
    localparam logic [7:0] OP_BE64 = 8'hD8;
    localparam logic [7:0] OP_CE1 = 8'hC7;
    localparam logic [7:0] OP_CE2 = 8'h60;
    localparam logic [7:0] OP_SUSP = 8'h75;
    localparam logic [7:0] OP_RESM = 8'h7A;
    localparam logic [7:0] OP_RSTEN = 8'h66;
    localparam logic [7:0] OP_RST = 8'h99;
    localparam logic [7:0] OP_DPD = 8'hB9;
    localparam logic [7:0] OP_RDPD = 8'hAB;
    localparam logic [7:0] OP_QPI_ON = 8'h38;
    localparam logic [7:0] OP_QPI_OFF = 8'hFF;
    localparam logic [7:0] OP_HPM = 8'hA3;

    // serial clock counts at which the frame fields complete
    localparam int CNT_W = 12;
    localparam logic [11:0] CNT_ONE = 12'h001;
    localparam logic [11:0] CNT_OP = 12'h008;
    localparam logic [11:0] CNT_B2 = 12'h010;
    localparam logic [11:0] CNT_B3 = 12'h018;
    localparam logic [11:0] CNT_ERASE = 12'h020;
    localparam logic [11:0] CNT_PP = 12'h028;
    localparam logic [2:0] BIT_TOP = 3'h7;
    localparam logic [2:0] BIT_ZERO = 3'h0;
    localparam int BYTE_W = 8;

    // protect modes and defaults
    localparam logic [1:0] SRP_SOFT = 2'h0;
    localparam logic [1:0] SRP_HW = 2'h1;
    localparam logic [1:0] SRP_LOCK = 2'h2;
    localparam logic [1:0] SRP_OTP = 2'h3;
    localparam logic [1:0] DRV_RESET = 2'h1;
    localparam logic [2:0] BP_CE_NONE = 3'h0;
    localparam logic [2:0] BP_CE_ALL = 3'h7;

    // array geometry for the protection decode
    localparam logic [5:0] BLK_COUNT = 6'h20;
    localparam logic [5:0] BLK_ONE = 6'h01;
    localparam logic [4:0] BLK_LAST = 5'h1F;
    localparam logic [4:0] BLK_FIRST = 5'h00;
    localparam logic [4:0] SEC_COUNT = 5'h10;
    localparam logic [4:0] SEC_HALF = 5'h08;
    localparam logic [4:0] SEC_ONE = 5'h01;

    // pin synchroniser reset: cs high, sclk low, hold high, wp high, oe low
    localparam logic [4:0] PIN_SYNC_RST = 5'h16;
    localparam int BUSY_W = 16;
    localparam logic [15:0] BUSY_ONE = 16'h0001;

    typedef struct packed {
        logic rsv23;
        logic [1:0] drv;
        logic high_perf_flag;
        logic [3:0] rsv_hi;
        logic erase_suspended_flag;
        logic cmp;
        logic [2:0] lb;
        logic program_suspended_flag;
        logic qe;
        logic [1:0] srp;
        logic [4:0] bp;
        logic write_enable_latch;
        logic write_in_progress;
    } status_t;

    typedef enum logic [3:0] {
        BUSY_IDLE = 4'b0001,
        BUSY_WRSR = 4'b0010,
        BUSY_PROG = 4'b0100,
        BUSY_ERASE = 4'b1000
    } busy_t;

    typedef struct packed {
        logic [7:0] op;
        logic [7:0] b2;
        logic [7:0] b3;
        logic [11:0] cnt;
    } frame_t;

    function automatic logic is_read(input logic [7:0] op);
        return op == OP_RDSR1 || op == OP_RDSR2 || op == OP_RDSR3;
    endfunction

    function automatic logic [7:0] rd_byte(input logic [7:0] op,
                                           input logic [23:0] w);
        case (op)
            OP_RDSR2: return w[BYTE_W +: BYTE_W];
            OP_RDSR3: return w[2 * BYTE_W +: BYTE_W];
            default: return w[0 +: BYTE_W];
        endcase
    endfunction

    // block and sector granular protected-region decode
    function automatic logic addr_protected(input logic [4:0] blk,
                                            input logic [3:0] sec,
                                            input logic [4:0] bp,
                                            input logic cmp);
        logic hit;
        logic [5:0] nblk;
        logic [4:0] nsec;
        begin
            nblk = BLK_ONE << (bp[2:0] - 3'h1);
            nsec = bp[2] ? SEC_HALF : SEC_ONE << (bp[1:0] - 2'h1);
            if (bp[2:1] == 2'h3)
                hit = 1'b1;
            else if (bp[2:0] == BP_CE_NONE)
                hit = 1'b0;
            else if (!bp[4])
                hit = bp[3] ? ({1'b0, blk} < nblk)
                            : ({1'b0, blk} >= BLK_COUNT - nblk);
            else
                hit = bp[3] ? (blk == BLK_FIRST && {1'b0, sec} < nsec)
                            : (blk == BLK_LAST &&
                               {1'b0, sec} >= SEC_COUNT - nsec);
            return hit ^ cmp;
        end
    endfunction
endpackage

// >>> hdl/pin_sync.sv
// two flip-flop level synchroniser with a settable reset value
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_r <= RST;
            q_r <= RST;
        end
        else
        begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end

    assign q = q_r;
endmodule

// >>> bench/spi_host.sv
// host spi controller model driving the flash pins
module spi_host
(
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    output logic hold_n,
    output logic wp_n,
    input wire logic miso
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
        hold_n = 1'b1;
        wp_n = 1'b1;
    end
    // n bits msb first, pause before bit p, ab drops the frame there
    task automatic xfer(input logic [23:0] d, input int n, input int p,
                        input logic ab, output logic [7:0] rd);
        cs_n = 1'b0;
        #60;
        for (int i = 0; i <= n; i++)
        begin
            if (i == p)
            begin
                #10 hold_n = 1'b0;
                #60 sclk = 1'b1;
                #15 sclk = 1'b0;
                #60;
                if (ab)
                begin
                    cs_n = 1'b1;
                    #60 hold_n = 1'b1;
                    return;
                end
                hold_n = 1'b1;
                #60;
            end
            if (i < n)
            begin
                // bits past the 24-bit word are sent as zero
                mosi = i < 24 ? d[23 - i] : 1'b0;
                #15 sclk = 1'b1;
                rd = {rd[6:0], miso};
                #15 sclk = 1'b0;
            end
        end
        #60 cs_n = 1'b1;
        // released data line must not look like a held value
        mosi = ~mosi;
    endtask
endmodule

// >>> bench/flash_status_protect_hold_bench.sv
// self-checking bench for the flash status and protection block
module flash_status_protect_hold_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import flash_pkg::*;
    logic clk, nrst, sclk, cs_n, mosi, hold_n, wp_n, miso, miso_oe;
    logic qio, qcm, dpd, busy;
    logic [7:0] rd;
    status_t st;
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int oe_hits = 0;
    // long busy span so that a suspend frame can land inside it
    flash_status_protect_hold #(.BUSY_CYCLES(64)) u_flash_status_protect_hold
    (
        .clk(clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
        .hold_n(hold_n), .wp_n(wp_n), .miso(miso), .miso_oe(miso_oe),
        .status(st), .quad_io_enable(qio), .quad_command_mode(qcm),
        .deep_power_down(dpd)
    );
    spi_host u_spi_host
    (
        .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .hold_n(hold_n),
        .wp_n(wp_n), .miso(miso)
    );
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 10000)
        begin
            num_errors++;
            report_and_stop();
        end
    end
    always @(negedge clk)
    begin
        if (miso_oe === 1'b1)
            oe_hits++;
    end
    // a pause floats the output well before hold is released
    always @(negedge hold_n)
    begin
        #100;
        check(24'(miso_oe), 24'h0);
    end
    task automatic check(input logic [23:0] s, input logic [23:0] e);
        n_checks++;
        if (s !== e)
        begin
            num_errors++;
            $display("wrong value at %0t: %h expected %h", $time, s, e);
        end
    endtask
    // a frame, then watch long enough for the busy window to pass
    task automatic fr(input logic [23:0] d, input int n, input int p,
                      input logic ab);
        u_spi_host.xfer(d, n, p, ab, rd);
        busy = 1'b0;
        repeat (16)
        begin
            @(negedge clk);
            busy |= st.write_in_progress;
        end
        while (st.write_in_progress)
            @(negedge clk);
    endtask
    task automatic cmd(input logic [7:0] op);
        fr({op, 16'h0000}, 8, 99, 1'b0);
    endtask
    task automatic wr(input logic [7:0] op, input logic [7:0] v);
        cmd(OP_WREN);
        fr({op, v, 8'h00}, 16, 99, 1'b0);
    endtask
    task automatic rst();
        nrst = 1'b0;
        repeat (8) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
    endtask
    initial
    begin
        rst();
        check(st, 24'h200000);
        check(24'({qio, qcm, dpd}), 24'h0);
        cmd(OP_WREN);
        check(24'(st.write_enable_latch), 24'h1);
        cmd(OP_WRDI);
        check(24'(st.write_enable_latch), 24'h0);
        fr({OP_WREN, 16'h0000}, 8, 4, 1'b0);
        check(24'(st.write_enable_latch), 24'h1);
        cmd(OP_WRDI);
        fr({OP_WREN, 16'h0000}, 8, 8, 1'b1);
        check(24'(st.write_enable_latch), 24'h0);
        fr({OP_WRSR, 8'h0C, 8'h00}, 16, 99, 1'b0);
        check(24'(st.bp), 24'h0);
        wr(OP_WRSR, 8'h0C);
        check(24'(busy), 24'h1);
        check(24'({st.bp, st.write_enable_latch}), 24'h06);
        fr({OP_RDSR1, 16'h0000}, 16, 99, 1'b0);
        check(24'(rd), 24'h0C);
        oe_hits = 0;
        fr({OP_RDSR1, 16'h0000}, 16, 12, 1'b0);
        check(24'({oe_hits != 0, rd}), 24'h10C);
        cmd(OP_WREN);
        cmd(OP_CE1);
        check(24'(busy), 24'h0);
        wr(OP_WRSR, 8'h00);
        cmd(OP_WREN);
        cmd(OP_CE2);
        check(24'(busy), 24'h1);
        wr(OP_WRSR2, 8'h40);
        cmd(OP_WREN);
        fr({OP_SE, 16'h0000}, 32, 99, 1'b0);
        check(24'({busy, st.write_enable_latch, st.cmp}), 24'h1);
        wr(OP_WRSR2, 8'h00);
        wr(OP_WRSR, 8'h04);
        cmd(OP_WREN);
        fr({OP_SE, 8'h1F, 8'h00}, 32, 99, 1'b0);
        check(24'({busy, st.write_enable_latch}), 24'h0);
        cmd(OP_WREN);
        fr({OP_SE, 16'h0000}, 32, 99, 1'b0);
        check(24'(busy), 24'h1);
        cmd(OP_WREN);
        u_spi_host.xfer({OP_SE, 16'h0000}, 32, 99, 1'b0, rd);
        repeat (6) @(negedge clk);
        cmd(OP_SUSP);
        check(24'({st.erase_suspended_flag, st.program_suspended_flag, st.write_in_progress}), 24'h4);
        cmd(OP_RESM);
        check(24'({st.erase_suspended_flag, busy}), 24'h1);
        wr(OP_WRSR, 8'h80);
        check(24'(st.srp), 24'h1);
        u_spi_host.wp_n = 1'b0;
        wr(OP_WRSR, 8'h84);
        check(24'(st.bp), 24'h0);
        u_spi_host.wp_n = 1'b1;
        wr(OP_WRSR, 8'h04);
        check(24'(st.bp), 24'h1);
        wr(OP_WRSR2, 8'h01);
        wr(OP_WRSR, 8'h08);
        check(24'({st.srp, st.bp}), 24'h41);
        rst();
        check(24'(st.srp), 24'h0);
        wr(OP_WRSR, 8'h80);
        wr(OP_WRSR2, 8'h01);
        wr(OP_WRSR, 8'h84);
        check(24'({st.srp, st.bp}), 24'h60);
        rst();
        cmd(OP_QPI_ON);
        check(24'(qcm), 24'h0);
        wr(OP_WRSR2, 8'h02);
        check(24'(qio), 24'h1);
        cmd(OP_QPI_ON);
        wr(OP_WRSR2, 8'h00);
        check(24'({qcm, qio}), 24'h3);
        wr(OP_WRSR2, 8'h08);
        wr(OP_WRSR2, 8'h00);
        check(24'({st.lb, st.qe}), 24'h3);
        cmd(OP_HPM);
        check(24'(st.high_perf_flag), 24'h1);
        cmd(OP_DPD);
        cmd(OP_WREN);
        check(24'({dpd, st.write_enable_latch}), 24'h2);
        cmd(OP_RDPD);
        check(24'(dpd), 24'h0);
        report_and_stop();
    end
endmodule
